// [verif/spcc_board_model.sv]
// Board model: strap resistors, pin wires and serial EEPROM data-out
`timescale 1ns/1ns
module spcc_board_model (
  input  wire logic       pclk,
  input  wire logic [7:0] cfg,
  input  wire logic [7:0] ext_level,
  input  wire logic [7:0] gio_out,
  input  wire logic [7:0] gio_oe_n,
  input  wire logic       eeprom_cs,
  input  wire logic       eeprom_di,
  output logic            prescaler_select_strap,
  output logic      [2:0] osc_freq_strap,
  output logic      [1:0] line_iface_strap,
  output logic      [1:0] toggle_source_strap,
  output logic      [7:0] gio_in,
  output logic            eeprom_do
);
  logic last_di;
  assign {prescaler_select_strap, osc_freq_strap, line_iface_strap, toggle_source_strap} = cfg;
  assign gio_in = (~gio_oe_n & gio_out) | (gio_oe_n & ext_level);
  // deselected line shows inverse of data-in as registered one pclk earlier
  assign eeprom_do = eeprom_cs ? ~eeprom_di : ~last_di;
  always_ff @(posedge pclk) last_di <= eeprom_di;
endmodule : spcc_board_model

// [verif/spcc_strap_capture_props.sv]
// Port assertions for the strap capture block
`timescale 1ns/1ns
`include "spcc_map.svh"
module spcc_strap_capture_chk
  import spcc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  line_type,
  input wire logic [7:0]  uart_rts_n,
  input wire logic [7:0]  request_to_send_out_n,
  input wire logic [7:0]  gio_oe_n,
  input wire logic        eeprom_cs,
  input wire logic        eeprom_sk,
  input wire logic        eeprom_di
);
  logic setup;
  logic wr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite;
  ready_high_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (setup && paddr > 8'h1c |=> pslverr)
    else $error("no slave error");
  write_rdata_a: assert property (setup && pwrite |=> prdata == 32'h0)
    else $error("read data on write");
  read_upper_a: assert property (setup |=> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  line_field_a: assert property (
    setup && !pwrite && paddr == `SPCC_OFF_IFACE_INFO |=> prdata[5:4] == line_type)
    else $error("line field differs");
  // Internal reset release lags the pin, hence the deep past
  rts_pass_a: assert property (
    $past(presetn, 4) && line_type == SPCC_LINE_RS232 |-> request_to_send_out_n == $past(uart_rts_n))
    else $error("rts not passed through");
  eeprom_pins_a: assert property (
    wr && paddr == `SPCC_OFF_EEPROM |-> ##2 {eeprom_di, eeprom_sk, eeprom_cs} == $past(pwdata[2:0], 2))
    else $error("eeprom pins wrong");
  gio_dir_a: assert property (
    wr && paddr == `SPCC_OFF_GIO_OE |-> ##2 gio_oe_n == ~$past(pwdata[7:0], 2))
    else $error("pin direction wrong");
endmodule : spcc_strap_capture_chk

bind spcc_strap_capture spcc_strap_capture_chk spcc_strap_capture_chk_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .line_type,
  .uart_rts_n, .request_to_send_out_n, .gio_oe_n, .eeprom_cs, .eeprom_sk, .eeprom_di);

// [verif/spcc_strap_capture_tb.sv]
// Self-checking bench for the strap capture block
`timescale 1ns/1ns
`include "spcc_map.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module spcc_strap_capture_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        prescaler_select_strap, prescaler_div4;
  logic        eeprom_cs, eeprom_sk, eeprom_di, eeprom_do;
  logic [7:0]  paddr, cfg, ext, uart_tx_active, uart_rts_n, uart_dtr_n;
  logic [7:0]  gio_in, gio_out, gio_oe_n, request_to_send_out_n, terminal_ready_out_n;
  logic [7:0]  driver_enable_out, receiver_enable_out_n;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  osc_freq_strap;
  logic [1:0]  line_iface_strap, toggle_source_strap, line_type;
  int          checked = 0;
  int          failures = 0;
  // Fields: prescaler, osc code, line code, toggle source
  localparam logic [7:0] CFGS [6] = '{8'h80, 8'h54, 8'hea, 8'h7f, 8'hb9, 8'h17};
  spcc_strap_capture spcc_strap_capture_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .prescaler_select_strap, .osc_freq_strap,
    .line_iface_strap, .toggle_source_strap, .prescaler_div4, .line_type, .uart_tx_active,
    .uart_rts_n, .uart_dtr_n, .request_to_send_out_n, .terminal_ready_out_n,
    .driver_enable_out, .receiver_enable_out_n, .gio_in, .gio_out, .gio_oe_n, .eeprom_cs,
    .eeprom_sk, .eeprom_di, .eeprom_do);
  spcc_board_model spcc_board_model_i (.pclk, .cfg, .ext_level(ext), .gio_out, .gio_oe_n,
    .eeprom_cs, .eeprom_di, .prescaler_select_strap, .osc_freq_strap, .line_iface_strap,
    .toggle_source_strap, .gio_in, .eeprom_do);
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait states end only by the answer or the watchdog
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Straps settle through synchronisers, so hold five cycles
  task automatic do_reset(input logic [7:0] c);
    cfg            <= c;
    uart_tx_active <= 8'h00;
    presetn        <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : do_reset
  task automatic t_straps();
    logic tg;
    logic ded;
    foreach (CFGS[i]) begin
      do_reset(CFGS[i]);
      `CHK(prescaler_div4, ~CFGS[i][7])
      apb(1'b0, `SPCC_OFF_MODEM_CTRL, 32'h0);
      `CHK(rd, {24'h0, ~CFGS[i][7], 7'h0})
      apb(1'b1, `SPCC_OFF_OPTION_INFO, 32'hff);
      apb(1'b0, `SPCC_OFF_OPTION_INFO, 32'h0);
      `CHK(rd, {29'h0, CFGS[i][6:4]})
      apb(1'b1, `SPCC_OFF_IFACE_INFO, 32'hff);
      apb(1'b0, `SPCC_OFF_IFACE_INFO, 32'h0);
      `CHK(rd, {26'h0, CFGS[i][3:2], 2'h0, CFGS[i][1:0]})
      `CHK(line_type, CFGS[i][3:2])
      apb(1'b1, `SPCC_OFF_AUTO_TOGGLE, 32'ha0);
      uart_tx_active <= 8'h01;
      repeat (3) @(posedge pclk);
      tg  = (CFGS[i][3:2] == 2'h1) || (CFGS[i][3:2] == 2'h2);
      ded = tg && CFGS[i][1:0] == 2'h2;
      `CHK(request_to_send_out_n, (tg && CFGS[i][1:0] == 2'h0) ? 8'ha4 : 8'ha5)
      `CHK(terminal_ready_out_n, (tg && CFGS[i][1:0] == 2'h1) ? 8'hc2 : 8'hc3)
      `CHK(driver_enable_out, ded ? 8'h01 : 8'h00)
      `CHK(receiver_enable_out_n, ded ? 8'h01 : 8'h00)
    end
  endtask : t_straps
  task automatic t_regs();
    apb(1'b1, `SPCC_OFF_MODEM_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK(prescaler_div4, 1'b0)
    apb(1'b1, `SPCC_OFF_GIO_OE, 32'h0f);
    apb(1'b1, `SPCC_OFF_GIO_OUT, 32'h05);
    repeat (5) @(posedge pclk);
    `CHK(gio_oe_n, 8'hf0)
    apb(1'b0, `SPCC_OFF_GIO_IN, 32'h0);
    `CHK(rd, 32'h95)
    apb(1'b1, `SPCC_OFF_EEPROM, 32'h07);
    repeat (4) @(posedge pclk);
    `CHK({eeprom_di, eeprom_sk, eeprom_cs}, 3'h7)
    apb(1'b0, `SPCC_OFF_EEPROM, 32'h0);
    `CHK(rd, 32'h07)
    apb(1'b1, `SPCC_OFF_EEPROM, 32'h03);
    repeat (4) @(posedge pclk);
    apb(1'b0, `SPCC_OFF_EEPROM, 32'h0);
    `CHK(rd, 32'h0b)
    apb(1'b1, 8'h40, 32'hff);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
  endtask : t_regs
  task automatic finish_test();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {cfg, ext, uart_tx_active} = {8'h80, 8'h96, 8'h00};
    {uart_rts_n, uart_dtr_n} = {8'ha5, 8'hc3};
    t_straps();
    t_regs();
    finish_test();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    finish_test();
  end
endmodule : spcc_strap_capture_tb

// [verilog/spcc_map.svh]
// Register offsets, field positions and reset values of the strap capture block
`ifndef SPCC_MAP_SVH
`define SPCC_MAP_SVH
`define SPCC_OFF_MODEM_CTRL   8'h00
`define SPCC_OFF_OPTION_INFO  8'h04
`define SPCC_OFF_IFACE_INFO   8'h08
`define SPCC_OFF_AUTO_TOGGLE  8'h0c
`define SPCC_OFF_GIO_OE       8'h10
`define SPCC_OFF_GIO_OUT      8'h14
`define SPCC_OFF_GIO_IN       8'h18
`define SPCC_OFF_EEPROM       8'h1c
`define SPCC_CTL_PRESCALE_BIT 7
`define SPCC_OSC_MSB          2
`define SPCC_OSC_LSB          0
`define SPCC_IFACE_MSB        5
`define SPCC_IFACE_LSB        4
`define SPCC_TOGSRC_MSB       1
`define SPCC_TOGSRC_LSB       0
`define SPCC_TOG_DRIVER_BIT   5
`define SPCC_TOG_RECEIVER_BIT 7
`define SPCC_EE_CS_BIT        0
`define SPCC_EE_SK_BIT        1
`define SPCC_EE_DI_BIT        2
`define SPCC_EE_DO_BIT        3
`define SPCC_RST_MODEM_CTRL   8'h00
`define SPCC_RST_AUTO_TOGGLE  8'h00
`define SPCC_RST_GIO_OE       8'h00
`define SPCC_RST_GIO_OUT      8'h00
`define SPCC_RST_EEPROM       4'h0
`endif

// [verilog/spcc_pkg.sv]
// Types shared by the strap capture block
package spcc_pkg;
  typedef enum logic [2:0] {
    SPCC_ST_RESET   = 3'b001,
    SPCC_ST_CAPTURE = 3'b010,
    SPCC_ST_RUN     = 3'b100
  } spcc_state_t;
  typedef enum logic [1:0] {
    SPCC_TOG_RTS       = 2'h0,
    SPCC_TOG_DTR       = 2'h1,
    SPCC_TOG_DEDICATED = 2'h2,
    SPCC_TOG_NONE      = 2'h3
  } spcc_togsrc_t;
  typedef enum logic [1:0] {
    SPCC_LINE_RS232 = 2'h0,
    SPCC_LINE_RS422 = 2'h1,
    SPCC_LINE_RS485 = 2'h2,
    SPCC_LINE_RSVD  = 2'h3
  } spcc_line_t;
endpackage : spcc_pkg

// [verilog/spcc_strap_capture.sv]
// Strap capture, general I/O pins, line toggle steering and EEPROM pins behind APB
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "spcc_map.svh"

module spcc_strap_capture
  import spcc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic            pready,
  output logic            pslverr,
  input  wire logic       prescaler_select_strap,
  input  wire logic [2:0] osc_freq_strap,
  input  wire logic [1:0] line_iface_strap,
  input  wire logic [1:0] toggle_source_strap,
  output logic            prescaler_div4,
  output logic      [1:0] line_type,
  input  wire logic [7:0] uart_tx_active,
  input  wire logic [7:0] uart_rts_n,
  input  wire logic [7:0] uart_dtr_n,
  output logic      [7:0] request_to_send_out_n,
  output logic      [7:0] terminal_ready_out_n,
  output logic      [7:0] driver_enable_out,
  output logic      [7:0] receiver_enable_out_n,
  input  wire logic [7:0] gio_in,
  output logic      [7:0] gio_out,
  output logic      [7:0] gio_oe_n,
  output logic            eeprom_cs,
  output logic            eeprom_sk,
  output logic            eeprom_di,
  input  wire logic       eeprom_do
);

  // Reset release synchroniser
  logic        rst_meta;
  logic        rst_sync;
  spcc_state_t state;
  spcc_state_t next_state;

  // Pin synchronisers; no reset so straps are tracked during reset
  logic       presc_meta;
  logic       presc_sync;
  logic [2:0] osc_meta;
  logic [2:0] osc_sync;
  logic [1:0] line_meta;
  logic [1:0] line_sync;
  logic [1:0] tog_meta;
  logic [1:0] tog_sync;
  logic [7:0] gio_meta;
  logic [7:0] gio_sync;
  logic       eedo_meta;
  logic       eedo_sync;

  // Registers
  logic [7:0] modem_control_reg;
  logic [2:0] osc_freq_field;
  logic [1:0] iface_info_field;
  logic [1:0] toggle_source_field;
  logic [7:0] auto_toggle_reg;
  logic [7:0] general_io_output_enable;
  logic [7:0] general_io_output_level;
  logic [7:0] general_io_input_level;
  logic [3:0] eeprom_ctrl;

  // Bus decode
  wire        setup_phase = psel & ~penable;
  wire        wr_access   = psel & penable & pwrite;
  wire        hit_modem   = (paddr == `SPCC_OFF_MODEM_CTRL);
  wire        hit_opt     = (paddr == `SPCC_OFF_OPTION_INFO);
  wire        hit_ifc     = (paddr == `SPCC_OFF_IFACE_INFO);
  wire        hit_toggle  = (paddr == `SPCC_OFF_AUTO_TOGGLE);
  wire        hit_goe     = (paddr == `SPCC_OFF_GIO_OE);
  wire        hit_gout    = (paddr == `SPCC_OFF_GIO_OUT);
  wire        hit_gin     = (paddr == `SPCC_OFF_GIO_IN);
  wire        hit_ee      = (paddr == `SPCC_OFF_EEPROM);
  wire        hit_any     = hit_modem | hit_opt | hit_ifc | hit_toggle |
                            hit_goe | hit_gout | hit_gin | hit_ee;
  wire        capture     = (state == SPCC_ST_CAPTURE);
  wire        running     = (state == SPCC_ST_RUN);

  wire [7:0]  opt_word;
  wire [7:0]  ifc_word;
  wire [7:0]  ee_word;
  wire [31:0] rd_mux;

  assign opt_word = {5'h00, osc_freq_field};
  // Line type and toggle source fields
  assign ifc_word = {2'h0, iface_info_field, 2'h0, toggle_source_field};
  assign ee_word  = {4'h0, eedo_sync, eeprom_ctrl[2:0]};

  assign rd_mux = hit_modem ? {24'h000000, modem_control_reg} :
                  hit_opt  ? {24'h000000, opt_word} :
                  hit_ifc  ? {24'h000000, ifc_word} :
                  hit_toggle ? {24'h000000, auto_toggle_reg} :
                  hit_goe  ? {24'h000000, general_io_output_enable} :
                  hit_gout ? {24'h000000, general_io_output_level} :
                  hit_gin  ? {24'h000000, general_io_input_level} :
                  hit_ee   ? {24'h000000, ee_word} : 32'h00000000;

  // Single-cycle access phase; data prepared in setup
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  always_ff @(posedge pclk) begin
    presc_meta <= prescaler_select_strap;
    presc_sync <= presc_meta;
    osc_meta   <= osc_freq_strap;
    osc_sync   <= osc_meta;
    line_meta  <= line_iface_strap;
    line_sync  <= line_meta;
    tog_meta   <= toggle_source_strap;
    tog_sync   <= tog_meta;
    gio_meta   <= gio_in;
    gio_sync   <= gio_meta;
    eedo_meta  <= eeprom_do;
    eedo_sync  <= eedo_meta;
  end

  // Capture sequencer: one capture cycle after synced release
  always_comb begin
    case (state)
      SPCC_ST_RESET:   next_state = rst_sync ? SPCC_ST_CAPTURE : SPCC_ST_RESET;
      SPCC_ST_CAPTURE: next_state = SPCC_ST_RUN;
      SPCC_ST_RUN:     next_state = SPCC_ST_RUN;
      default:         next_state = SPCC_ST_RESET;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SPCC_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Inverted prescaler strap loaded at release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_control_reg <= `SPCC_RST_MODEM_CTRL;
    end else if (capture) begin
      modem_control_reg[`SPCC_CTL_PRESCALE_BIT] <= ~presc_sync;
    end else if (wr_access && hit_modem && running) begin
      modem_control_reg <= pwdata[7:0];
    end
  end

  // Strap fields change only at capture
  // Codes stored as seen, no remapping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_freq_field      <= 3'h0;
      iface_info_field    <= 2'h0;
      toggle_source_field <= 2'h0;
    end else if (capture) begin
      osc_freq_field      <= osc_sync;
      iface_info_field    <= line_sync;
      toggle_source_field <= tog_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_toggle_reg          <= `SPCC_RST_AUTO_TOGGLE;
      general_io_output_enable <= `SPCC_RST_GIO_OE;
      general_io_output_level  <= `SPCC_RST_GIO_OUT;
      eeprom_ctrl              <= `SPCC_RST_EEPROM;
    end else if (wr_access) begin
      if (hit_toggle) begin
        auto_toggle_reg <= pwdata[7:0];
      end
      if (hit_goe) begin
        general_io_output_enable <= pwdata[7:0];
      end
      if (hit_gout) begin
        general_io_output_level <= pwdata[7:0];
      end
      if (hit_ee) begin
        eeprom_ctrl <= {1'b0, pwdata[2:0]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_io_input_level <= 8'h00;
    end else begin
      general_io_input_level <= gio_sync;
    end
  end

  // Read data and error decided in setup, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~hit_any;
    end
  end

  // Live inverted strap during reset, latched bit after
  always_ff @(posedge pclk) begin
    prescaler_div4 <= running ? modem_control_reg[`SPCC_CTL_PRESCALE_BIT] : ~presc_sync;
  end

  // Line transceiver type out of captured code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_type <= SPCC_LINE_RS232;
    end else begin
      line_type <= iface_info_field;
    end
  end

  // Toggle steering; code 3 passes UART levels, no toggling
  wire sel_rts = (toggle_source_field == SPCC_TOG_RTS);
  wire sel_dtr = (toggle_source_field == SPCC_TOG_DTR);
  wire sel_ded = (toggle_source_field == SPCC_TOG_DEDICATED);
  wire drv_val = auto_toggle_reg[`SPCC_TOG_DRIVER_BIT];
  wire rcv_val = auto_toggle_reg[`SPCC_TOG_RECEIVER_BIT];
  // RS232 never toggles, only RS422 and RS485 drive switching
  wire tog_ok  = running && (iface_info_field == SPCC_LINE_RS422 ||
                             iface_info_field == SPCC_LINE_RS485);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_to_send_out_n <= 8'hff;
      terminal_ready_out_n  <= 8'hff;
      driver_enable_out     <= 8'h00;
      receiver_enable_out_n <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        // RTS or DTR pin carries inverted driver level in transmit
        request_to_send_out_n[i] <= (tog_ok && sel_rts && uart_tx_active[i]) ?
                                    ~drv_val : uart_rts_n[i];
        terminal_ready_out_n[i]  <= (tog_ok && sel_dtr && uart_tx_active[i]) ?
                                    ~drv_val : uart_dtr_n[i];
        driver_enable_out[i]     <= (tog_ok && sel_ded && uart_tx_active[i]) ?
                                    drv_val : ~drv_val;
        receiver_enable_out_n[i] <= (tog_ok && sel_ded && uart_tx_active[i]) ?
                                    rcv_val : ~rcv_val;
      end
    end
  end

  // Pin drivers, enable low while driving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gio_out  <= 8'h00;
      gio_oe_n <= 8'hff;
    end else begin
      gio_out  <= general_io_output_level;
      gio_oe_n <= ~general_io_output_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eeprom_cs <= 1'b0;
      eeprom_sk <= 1'b0;
      eeprom_di <= 1'b0;
    end else begin
      eeprom_cs <= eeprom_ctrl[`SPCC_EE_CS_BIT];
      eeprom_sk <= eeprom_ctrl[`SPCC_EE_SK_BIT];
      eeprom_di <= eeprom_ctrl[`SPCC_EE_DI_BIT];
    end
  end

endmodule : spcc_strap_capture
